// ### hdl/rhcs_pkg.sv
// Constants and carrier types for the RAM-DAC host configuration block.
// Assumes a single pixel-clock domain and a synchronous parallel host port.
package rhcs_pkg;

	// Port select codes, {port_select_high, port_select_low}
	localparam logic [1:0] SEL_ADDR = 2'h0;
	localparam logic [1:0] SEL_PAL  = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	localparam logic [1:0] SEL_MODE = 2'h3;

	// Indirect address register values
	localparam logic [7:0] OFS_PAL   = 8'h00;
	localparam logic [7:0] OFS_MASK  = 8'h04;
	localparam logic [7:0] OFS_CTRL1 = 8'h05;
	localparam logic [7:0] OFS_CTRL2 = 8'h06;
	localparam logic [7:0] OFS_CTRL3 = 8'h07;

	// Reset values
	localparam logic [7:0] RST_ADDR  = 8'h00;
	localparam logic [7:0] RST_MASK  = 8'h00;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] RST_MODE  = 8'h00;

	// Field positions
	localparam int CR1_CAL_BIT   = 0;
	localparam int CR2_COLOR_LSB = 5;
	localparam int CR2_PED_BIT   = 3;
	localparam int CR2_SYNC_BIT  = 2;
	localparam int CR3_MUX_BIT   = 6;
	localparam int CR3_DIV8_BIT  = 0;
	localparam int MODE_PIPE_BIT = 0;
	localparam int MODE_LOAD_BIT = 5;
	localparam logic [2:0] COLOR_24 = 3'h7;

	// Palette depth and clock period
	localparam int PAL_DEPTH     = 256;
	localparam int CLK_PERIOD_NS = 10;

	// Palette component sequencer
	typedef enum logic [1:0] {
		RHCS_RED   = 2'b00,
		RHCS_GREEN = 2'b01,
		RHCS_BLUE  = 2'b10
	} rhcs_comp_t;

	typedef struct packed {
		logic       sel_high;
		logic       sel_low;
		logic       rd_wr_n;
		logic [9:0] data;
	} rhcs_req_t;

	typedef struct packed {
		logic [9:0] red;
		logic [9:0] green;
		logic [9:0] blue;
	} rhcs_rgb_t;

endpackage

// ### hdl/rhcs_top.sv
// Host configuration port of a video RAM-DAC: address, mask, control,
// mode registers, palette RAM and the derived pixel-side controls.
// Assumes host pins synchronous to CLK; each CLK cycle with CE and ACC_STB both high is one access.
//
// Contract
// - Address 05H, 06H, 07H select control registers one, two, three.
// - Address 00H selects the palette starting at location zero.
// - Each palette entry takes three ten-bit writes: red, green, blue.
// - Mask value FFH lets every pixel bit through to the lookup.
// - Control one at 01H calibrates once on every vertical sync.
// - Control two at E0H gives 24-bit colour, zero pedestal, no sync.
// - Control three at 41H gives 2:1 mux and inverted clock over eight.
// - Pipeline bit written one, zero, one resets the pixel pipelines to the A mux input.
// - Load-timing bit written zero, one, zero resynchronises load timing.
`timescale 1ns/100ps
`default_nettype none
module rhcs_top
	import rhcs_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	input  wire logic       ACC_STB,
	input  wire rhcs_req_t  REQ,
	output logic      [9:0] DATA_OUT,
	output logic            DATA_OE,
	input  wire logic [7:0] PIXEL_IN,
	input  wire logic       VSYNC,
	output rhcs_rgb_t       RGB_OUT,
	output logic      [7:0] PIXEL_MASK,
	output logic            CALIB_STB,
	output logic            COLOR_24BIT,
	output logic            PEDESTAL_7P5,
	output logic            SYNC_EN,
	output logic            MUX_2TO1,
	output logic            MUX_SEL,
	output logic            PIPE_RST,
	output logic            LOAD_SYNC,
	output logic            PRG_CLK_OUT
);

////////////////////////////////////////////////////////////////////////////
	logic [7:0]  addr_q;
	logic [7:0]  mask_q, ctrl1_q, ctrl2_q, ctrl3_q, mode_q;
	logic [2:0]  pipe_hist_q, load_hist_q;
	rhcs_comp_t  comp_q;
	logic [9:0]  red_q, green_q;
	rhcs_rgb_t   pal_mem [PAL_DEPTH];
	logic        vsync_q, pipe_rst_q, load_sync_q;
	logic [2:0]  div_q;
	logic [7:0]  masked;
	logic        wr, rd;
	logic [1:0]  sel;

	// Access decode
	assign sel = {REQ.sel_high, REQ.sel_low};
	assign wr  = CE && ACC_STB && !REQ.rd_wr_n;
	assign rd  = CE && ACC_STB && REQ.rd_wr_n;

////////////////////////////////////////////////////////////////////////////
	// Address register; also the palette pointer
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			addr_q <= RST_ADDR;
		end else if (wr && sel == SEL_ADDR) begin
			addr_q <= REQ.data[7:0];
		end else if ((wr || rd) && sel == SEL_PAL && comp_q == RHCS_BLUE) begin
			addr_q <= addr_q + 8'h01;
		end
	end

	// Component sequencer; an address write restarts at red
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			comp_q <= RHCS_RED;
		end else if (wr && sel == SEL_ADDR) begin
			comp_q <= RHCS_RED;
		end else if ((wr || rd) && sel == SEL_PAL) begin
			case (comp_q)
			RHCS_RED:   comp_q <= RHCS_GREEN;
			RHCS_GREEN: comp_q <= RHCS_BLUE;
			default:    comp_q <= RHCS_RED;
			endcase
		end
	end

	// Staging of red and green; the entry is written whole on blue
	// so the display never sees a half-updated colour
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			red_q   <= 10'h000;
			green_q <= 10'h000;
		end else if (wr && sel == SEL_PAL) begin
			if (comp_q == RHCS_RED) begin
				red_q <= REQ.data;
			end
			if (comp_q == RHCS_GREEN) begin
				green_q <= REQ.data;
			end
		end
	end

	// Palette array, no reset
	always_ff @(posedge CLK) begin
		if (wr && sel == SEL_PAL && comp_q == RHCS_BLUE) begin
			pal_mem[addr_q] <= '{red_q, green_q, REQ.data};
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Control registers selected through the address register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mask_q  <= RST_MASK;
			ctrl1_q <= RST_CTRL;
			ctrl2_q <= RST_CTRL;
			ctrl3_q <= RST_CTRL;
		end else if (wr && sel == SEL_CTRL) begin
			case (addr_q)
			OFS_MASK:  mask_q  <= REQ.data[7:0];
			OFS_CTRL1: ctrl1_q <= REQ.data[7:0];
			OFS_CTRL2: ctrl2_q <= REQ.data[7:0];
			OFS_CTRL3: ctrl3_q <= REQ.data[7:0];
			default:   ;
			endcase
		end
	end

	// Mode register and the bit history of its last three writes
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_q      <= RST_MODE;
			pipe_hist_q <= 3'h0;
			load_hist_q <= 3'h7;
		end else if (wr && sel == SEL_MODE) begin
			mode_q      <= REQ.data[7:0];
			pipe_hist_q <= {pipe_hist_q[1:0], REQ.data[MODE_PIPE_BIT]};
			load_hist_q <= {load_hist_q[1:0], REQ.data[MODE_LOAD_BIT]};
		end
	end

	// Sequence detectors, one-cycle pulses after the completing write
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pipe_rst_q  <= 1'b0;
			load_sync_q <= 1'b0;
		end else if (CE) begin
			pipe_rst_q  <= wr && sel == SEL_MODE &&
				{pipe_hist_q[1:0], REQ.data[MODE_PIPE_BIT]} == 3'h5;
			load_sync_q <= wr && sel == SEL_MODE &&
				{load_hist_q[1:0], REQ.data[MODE_LOAD_BIT]} == 3'h2;
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Read-back of the selected register, one cycle after the strobe
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DATA_OUT <= 10'h000;
			DATA_OE  <= 1'b0;
		end else if (CE) begin
			DATA_OE <= rd;
			if (rd) begin
				case (sel)
				SEL_ADDR: DATA_OUT <= {2'h0, addr_q};
				SEL_MODE: DATA_OUT <= {2'h0, mode_q};
				SEL_PAL: begin
					case (comp_q)
					RHCS_RED:   DATA_OUT <= pal_mem[addr_q].red;
					RHCS_GREEN: DATA_OUT <= pal_mem[addr_q].green;
					default:    DATA_OUT <= pal_mem[addr_q].blue;
					endcase
				end
				default: begin
					case (addr_q)
					OFS_MASK:  DATA_OUT <= {2'h0, mask_q};
					OFS_CTRL1: DATA_OUT <= {2'h0, ctrl1_q};
					OFS_CTRL2: DATA_OUT <= {2'h0, ctrl2_q};
					OFS_CTRL3: DATA_OUT <= {2'h0, ctrl3_q};
					default:   DATA_OUT <= 10'h000;
					endcase
				end
				endcase
			end
		end
	end

////////////////////////////////////////////////////////////////////////////
	// Control decode
	assign PIXEL_MASK   = mask_q;
	assign COLOR_24BIT  = ctrl2_q[7:CR2_COLOR_LSB] == COLOR_24;
	assign PEDESTAL_7P5 = ctrl2_q[CR2_PED_BIT];
	assign SYNC_EN      = ctrl2_q[CR2_SYNC_BIT];
	assign MUX_2TO1     = ctrl3_q[CR3_MUX_BIT];
	assign PIPE_RST     = pipe_rst_q;
	assign LOAD_SYNC    = load_sync_q;

	// Masked pixel lookup, registered
	assign masked = PIXEL_IN & mask_q;
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RGB_OUT <= '0;
		end else if (CE) begin
			RGB_OUT <= pal_mem[masked];
		end
	end

	// Calibration strobe on each vertical sync rising edge
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			vsync_q   <= 1'b0;
			CALIB_STB <= 1'b0;
		end else if (CE) begin
			vsync_q   <= VSYNC;
			CALIB_STB <= VSYNC && !vsync_q && ctrl1_q[CR1_CAL_BIT];
		end
	end

	// Input mux phase; the pipeline reset returns it to input A
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			MUX_SEL <= 1'b0;
		end else if (CE) begin
			if (pipe_rst_q) begin
				MUX_SEL <= 1'b0;
			end else begin
				MUX_SEL <= MUX_2TO1 && !MUX_SEL;
			end
		end
	end

	// Clock divider; load resync realigns its phase
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			div_q <= 3'h0;
		end else if (CE) begin
			div_q <= load_sync_q ? 3'h0 : div_q + 3'h1;
		end
	end

	// Over eight inverted, else over four
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PRG_CLK_OUT <= 1'b0;
		end else if (CE) begin
			PRG_CLK_OUT <= ctrl3_q[CR3_DIV8_BIT] ? !div_q[2] : div_q[1];
		end
	end

////////////////////////////////////////////////////////////////////////////
	property p_addr_wr;
		@(posedge CLK) disable iff (!RST_N)
		wr && sel == SEL_ADDR |=> addr_q == $past(REQ.data[7:0]);
	endproperty
	a_addr_wr: assert property (p_addr_wr) else $error("address not loaded");

	property p_ctrl1;
		@(posedge CLK) disable iff (!RST_N)
		wr && sel == SEL_CTRL && addr_q == OFS_CTRL1
		|=> ctrl1_q == $past(REQ.data[7:0]) && ctrl2_q == $past(ctrl2_q);
	endproperty
	a_ctrl1: assert property (p_ctrl1) else $error("control one miswritten");

	property p_pal_start;
		@(posedge CLK) disable iff (!RST_N)
		wr && sel == SEL_ADDR && REQ.data[7:0] == OFS_PAL
		|=> addr_q == 8'h00 && comp_q == RHCS_RED;
	endproperty
	a_pal_start: assert property (p_pal_start) else $error("palette start");

	property p_advance;
		@(posedge CLK) disable iff (!RST_N)
		wr && sel == SEL_PAL && comp_q == RHCS_BLUE
		|=> addr_q == $past(addr_q) + 8'h01 && comp_q == RHCS_RED;
	endproperty
	a_advance: assert property (p_advance) else $error("no advance");

	property p_mask;
		@(posedge CLK) disable iff (!RST_N)
		mask_q == 8'hff |-> masked == PIXEL_IN;
	endproperty
	a_mask: assert property (p_mask) else $error("mask blocks pixels");

	property p_calib;
		@(posedge CLK) disable iff (!RST_N)
		CE && VSYNC && !vsync_q && ctrl1_q == 8'h01 |=> CALIB_STB ##1 !CALIB_STB || !CE;
	endproperty
	a_calib: assert property (p_calib) else $error("calibration missed");

	property p_mode24;
		@(posedge CLK) disable iff (!RST_N)
		ctrl2_q == 8'he0 |-> COLOR_24BIT && !PEDESTAL_7P5 && !SYNC_EN;
	endproperty
	a_mode24: assert property (p_mode24) else $error("colour mode decode");

	property p_pipe;
		@(posedge CLK) disable iff (!RST_N)
		CE && pipe_rst_q |=> !MUX_SEL;
	endproperty
	a_pipe: assert property (p_pipe) else $error("mux not at A");

	property p_load;
		@(posedge CLK) disable iff (!RST_N)
		CE && load_sync_q |=> div_q == 3'h0;
	endproperty
	a_load: assert property (p_load) else $error("load not resynced");

	property p_mux2;
		@(posedge CLK) disable iff (!RST_N)
		ctrl3_q == 8'h41 && CE && !pipe_rst_q |=> MUX_2TO1 && MUX_SEL != $past(MUX_SEL);
	endproperty
	a_mux2: assert property (p_mux2) else $error("mux not alternating");

endmodule
`default_nettype wire

// ### tb/rhcs_host.sv
// Host microprocessor model driving the RAM-DAC configuration port.
// Assumes it is the only driver of ACC_STB and REQ.
`timescale 1ns/100ps
`default_nettype none
module rhcs_host
	import rhcs_pkg::*;
(
	input  wire logic CLK,
	output logic      ACC_STB,
	output rhcs_req_t REQ
);
	initial begin
		ACC_STB = 1'b0;
		REQ     = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// One access, held through the rising edge that takes it
	task automatic acc(input logic [1:0] sel, input logic rd,
		input logic [9:0] dat);
		@(negedge CLK);
		ACC_STB <= 1'b1;
		REQ     <= {sel, rd, dat};
		@(posedge CLK);
	endtask

	// Released bus: stale data would hide a late sample, so invert it
	task automatic idle();
		@(negedge CLK);
		ACC_STB  <= 1'b0;
		REQ.data <= ~REQ.data;
	endtask

	// Mode register is reached directly, no address write first
	task automatic mode_wr(input logic [7:0] v);
		acc(SEL_MODE, 1'b0, {2'h0, v});
	endtask

	// Start-up sequence: pipeline bit 1,0,1 then load bit 0,1,0
	task automatic reset_seq();
		mode_wr(8'h0f);
		mode_wr(8'h0e);
		mode_wr(8'h0f);
		mode_wr(8'h2f);
		mode_wr(8'h0f);
	endtask

	// One palette entry, always red then green then blue
	task automatic pal_wr(input logic [29:0] c);
		acc(SEL_PAL, 1'b0, c[29:20]);
		acc(SEL_PAL, 1'b0, c[19:10]);
		acc(SEL_PAL, 1'b0, c[9:0]);
	endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the RAM-DAC host configuration block.
// Assumes the host model drives the port; CE is held high.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import rhcs_pkg::*;
;
	logic       CLK = 1'b0;
	logic       RST_N = 1'b0;
	logic       CE = 1'b1;
	logic       ACC_STB;
	rhcs_req_t  REQ;
	logic [9:0] DATA_OUT;
	logic       DATA_OE;
	logic [7:0] PIXEL_IN = 8'h00;
	logic       VSYNC = 1'b0;
	rhcs_rgb_t  RGB_OUT;
	logic [7:0] PIXEL_MASK;
	logic       CALIB_STB, COLOR_24BIT, PEDESTAL_7P5, SYNC_EN;
	logic       MUX_2TO1, MUX_SEL, PIPE_RST, LOAD_SYNC, PRG_CLK_OUT;
	int         fail_count = 0;
	int         checks_done = 0;
	int         pipe_n = 0, load_n = 0, cal_n = 0;
	logic       pipe_prev = 1'b0;
	logic [7:0] cv [3] = '{8'h01, 8'he0, 8'h41};
	logic [29:0] e0 = {10'h123, 10'h2a5, 10'h01c};
	logic [29:0] e1 = {10'h3c0, 10'h00f, 10'h255};

	always #5 CLK = ~CLK;

	rhcs_host i_rhcs_host (.CLK(CLK), .ACC_STB(ACC_STB), .REQ(REQ));

	rhcs_top i_rhcs_top (.CLK(CLK), .RST_N(RST_N), .CE(CE),
		.ACC_STB(ACC_STB), .REQ(REQ), .DATA_OUT(DATA_OUT),
		.DATA_OE(DATA_OE), .PIXEL_IN(PIXEL_IN), .VSYNC(VSYNC),
		.RGB_OUT(RGB_OUT), .PIXEL_MASK(PIXEL_MASK), .CALIB_STB(CALIB_STB),
		.COLOR_24BIT(COLOR_24BIT), .PEDESTAL_7P5(PEDESTAL_7P5),
		.SYNC_EN(SYNC_EN), .MUX_2TO1(MUX_2TO1), .MUX_SEL(MUX_SEL),
		.PIPE_RST(PIPE_RST), .LOAD_SYNC(LOAD_SYNC),
		.PRG_CLK_OUT(PRG_CLK_OUT));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [1:0] sel, input logic [9:0] v);
		i_rhcs_host.acc(sel, 1'b0, v);
	endtask

	// Read answers in the cycle after the taken edge
	task automatic rd_chk(input logic [1:0] sel, input logic [9:0] exp);
		i_rhcs_host.acc(sel, 1'b1, 10'h000);
		i_rhcs_host.idle();
		chk(DATA_OE === 1'b1 && DATA_OUT === exp, "read back");
	endtask

	// Pulse counters; the pipeline reset must leave the mux at input A
	always @(negedge CLK) begin
		pipe_n += (PIPE_RST === 1'b1);
		load_n += (LOAD_SYNC === 1'b1);
		cal_n  += (CALIB_STB === 1'b1);
		if (pipe_prev)
			chk(MUX_SEL === 1'b0, "mux not at A");
		pipe_prev = (PIPE_RST === 1'b1);
	end

	// Hang guard well inside the run length limit
	initial begin
		#900000;
		chk(1'b0, "timeout");
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		int t0, per, n;
		logic prev, m;
		repeat (12) @(negedge CLK);
		RST_N = 1'b1;
		chk(PIXEL_MASK === 8'h00 && COLOR_24BIT === 1'b0, "reset");
		i_rhcs_host.reset_seq();
		i_rhcs_host.idle();
		repeat (2) @(negedge CLK);
		chk(pipe_n == 1 && load_n == 1, "mode sequences");
		rd_chk(SEL_MODE, 10'h00f);
		wr(SEL_ADDR, 10'h004);
		wr(SEL_CTRL, 10'h0ff);
		rd_chk(SEL_CTRL, 10'h0ff);
		chk(PIXEL_MASK === 8'hff, "mask");
		for (int i = 0; i < 3; i++) begin
			wr(SEL_ADDR, 10'h005 + 10'(i));
			wr(SEL_CTRL, {2'h0, cv[i]});
			rd_chk(SEL_CTRL, {2'h0, cv[i]});
		end
		wr(SEL_ADDR, 10'h008);
		wr(SEL_CTRL, 10'h05a);
		rd_chk(SEL_CTRL, 10'h000);
		chk(COLOR_24BIT === 1'b1 && PEDESTAL_7P5 === 1'b0
			&& SYNC_EN === 1'b0, "control two");
		// Opposite settings, so a stuck-low decode cannot pass
		wr(SEL_ADDR, 10'h006);
		wr(SEL_CTRL, 10'h00c);
		i_rhcs_host.idle();
		chk(COLOR_24BIT === 1'b0 && PEDESTAL_7P5 === 1'b1
			&& SYNC_EN === 1'b1, "control two fields");
		wr(SEL_CTRL, 10'h0e0);
		i_rhcs_host.idle();
		chk(MUX_2TO1 === 1'b1, "mux mode");
		m = MUX_SEL;
		@(negedge CLK);
		chk(MUX_SEL === ~m, "mux phase");
		prev = PRG_CLK_OUT;
		t0 = -1;
		per = 0;
		for (n = 0; n < 40 && per == 0; n++) begin
			@(negedge CLK);
			if (prev === 1'b0 && PRG_CLK_OUT === 1'b1) begin
				if (t0 < 0)
					t0 = n;
				else
					per = n - t0;
			end
			prev = PRG_CLK_OUT;
		end
		chk(per == 8, "clock out period");
		i_rhcs_host.mode_wr(8'h0e);
		i_rhcs_host.mode_wr(8'h0f);
		i_rhcs_host.idle();
		repeat (3) @(negedge CLK);
		chk(pipe_n == 2 && load_n == 1, "pipe reset");
		VSYNC = 1'b1;
		repeat (4) @(negedge CLK);
		chk(cal_n == 1, "calibration");
		VSYNC = 1'b0;
		wr(SEL_ADDR, 10'h000);
		i_rhcs_host.pal_wr(e0);
		i_rhcs_host.pal_wr(e1);
		i_rhcs_host.idle();
		PIXEL_IN = 8'h01;
		repeat (2) @(negedge CLK);
		chk(RGB_OUT === e1, "entry one");
		PIXEL_IN = 8'h00;
		repeat (2) @(negedge CLK);
		chk(RGB_OUT === e0, "entry zero");
		wr(SEL_ADDR, 10'h000);
		rd_chk(SEL_PAL, e0[29:20]);
		wr(SEL_ADDR, 10'h004);
		wr(SEL_CTRL, 10'h0fe);
		i_rhcs_host.idle();
		PIXEL_IN = 8'h01;
		repeat (2) @(negedge CLK);
		chk(RGB_OUT === e0, "masked lookup");
		print_verdict();
	end
endmodule
`default_nettype wire
